// [shared/wfpd_pkg.sv]
`default_nettype none
package wfpd_pkg;
   localparam int NUM_FILTERS      = 4;
   localparam int FILTER_WORDS     = 8;
   localparam int MASK_BITS        = 31;
   // Filter word indices in load order
   localparam logic [2:0] WORD_CMD     = 3'h4;
   localparam logic [2:0] WORD_OFFSET  = 3'h5;
   localparam logic [2:0] WORD_CRC_LO  = 3'h6;
   localparam logic [2:0] WORD_CRC_HI  = 3'h7;
   // Field positions
   localparam int CMD_STRIDE       = 8;
   localparam int CMD_ENABLE_BIT   = 0;
   localparam int CMD_MCAST_BIT    = 3;
   localparam int OFFSET_STRIDE    = 8;
   localparam int CRC_STRIDE       = 16;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [7:0]  OFFSET_MAX = 8'hff;
   localparam logic [7:0]  DEST_ADDR_BYTES = 8'h06;
endpackage : wfpd_pkg
`default_nettype wire

// [rtl/wfpd_detector.sv]
`default_nettype none
module wfpd_detector #(
   parameter int NUM_FILTERS = wfpd_pkg::NUM_FILTERS
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // Filter register port
   input  wire logic        filter_wr_in,
   input  wire logic [31:0] filter_wdata_in,
   input  wire logic        filter_rd_in,
   output logic      [31:0] filter_rdata_out,
   // Control and status bits
   input  wire logic        wake_frame_enable_in,
   input  wire logic        low_power_state_in,
   input  wire logic        irq_select_in,
   input  wire logic        pme_select_in,
   input  wire logic        flag_clear_in,
   input  wire logic        broadcast_disable_in,
   // Receive stream, bytes from the destination address onward
   input  wire logic        rx_sof_in,
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_data_in,
   input  wire logic        rx_eof_in,
   input  wire logic        rx_fcs_ok_in,
   input  wire logic        rx_addr_match_in,
   // Outputs
   output logic             detect_active_out,
   output logic             normal_rx_enable_out,
   output logic             wake_frame_received_flag_out,
   output logic             host_irq_out,
   output logic             power_event_signal_out
);
   logic [31:0] filter_word_reg [wfpd_pkg::FILTER_WORDS];
   logic [2:0]  wr_index_reg;
   logic [2:0]  rd_index_reg;
   logic [7:0]  byte_pos_reg;
   logic        frame_open_reg;
   logic        is_mcast_reg;
   logic        is_broadcast_disable_reg;
   logic [NUM_FILTERS-1:0] hit;
   logic        active;
   logic        wake_event;

   // Low power forces detection regardless of the enable bit
   assign active = wake_frame_enable_in | low_power_state_in;

   // Filter words are loaded in a fixed order through one register
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wr_index_reg <= 3'h0;
         for (int i = 0; i < wfpd_pkg::FILTER_WORDS; i++) begin
            filter_word_reg[i] <= 32'h0;
         end
      end else if (filter_wr_in) begin
         // Bit 31 of each mask word is forced low
         if (wr_index_reg < wfpd_pkg::WORD_CMD) begin
            filter_word_reg[wr_index_reg] <= {1'b0, filter_wdata_in[30:0]};
         end else begin
            filter_word_reg[wr_index_reg] <= filter_wdata_in;
         end
         wr_index_reg <= wr_index_reg + 3'h1; // wraps after eighth
      end
   end

   // Reads walk the same order, with their own pointer
   // Reading never moves the write order, so a check read cannot corrupt a load
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rd_index_reg     <= 3'h0;
         filter_rdata_out <= 32'h0;
      end else if (filter_rd_in) begin
         filter_rdata_out <= filter_word_reg[rd_index_reg];
         rd_index_reg     <= rd_index_reg + 3'h1;
      end
   end

   // Frame position and multicast type from the first destination byte, broadcast from all six
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         byte_pos_reg   <= 8'h0;
         frame_open_reg <= 1'b0;
         is_mcast_reg   <= 1'b0;
         is_broadcast_disable_reg   <= 1'b0;
      end else if (rx_valid_in && rx_sof_in) begin
         byte_pos_reg   <= 8'h1; // offset zero is this byte
         frame_open_reg <= !rx_eof_in;
         is_mcast_reg   <= rx_data_in[0];
         is_broadcast_disable_reg   <= rx_data_in == 8'hff;
      end else if (rx_valid_in && frame_open_reg) begin
         // Saturates at OFFSET_MAX; every later byte keeps that position, so it can still fall in a window
         if (byte_pos_reg != wfpd_pkg::OFFSET_MAX) begin
            byte_pos_reg <= byte_pos_reg + 8'h1;
         end
         // Broadcast only if every destination byte reads all ones
         if (byte_pos_reg < wfpd_pkg::DEST_ADDR_BYTES && rx_data_in != 8'hff) begin
            is_broadcast_disable_reg <= 1'b0;
         end
         if (rx_eof_in) begin
            frame_open_reg <= 1'b0;
         end
      end
   end

   // One CRC engine per filter, fed only by masked bytes
   genvar g;
   generate
      for (g = 0; g < NUM_FILTERS; g++) begin : g_filter
         logic [7:0]  cmd;
         logic [7:0]  offset;
         logic [15:0] ref_crc;
         logic [30:0] mask;
         logic [7:0]  rel;
         logic        in_win;
         logic        take;
         logic [15:0] crc_next;
         logic [15:0] crc_reg;
         logic [15:0] crc_now;
         logic        type_ok;
         assign cmd     = filter_word_reg[wfpd_pkg::WORD_CMD][g*wfpd_pkg::CMD_STRIDE +: 8];
         assign offset  = filter_word_reg[wfpd_pkg::WORD_OFFSET][g*wfpd_pkg::OFFSET_STRIDE +: 8];
         assign ref_crc = filter_word_reg[(g < 2) ? wfpd_pkg::WORD_CRC_LO : wfpd_pkg::WORD_CRC_HI]
                                         [(g % 2)*wfpd_pkg::CRC_STRIDE +: 16];
         assign mask    = filter_word_reg[g][30:0];
         assign rel     = (rx_sof_in ? 8'h0 : byte_pos_reg) - offset;
         assign in_win  = (rx_sof_in ? 8'h0 : byte_pos_reg) >= offset && rel < 8'(wfpd_pkg::MASK_BITS);
         assign take    = rx_valid_in && (rx_sof_in || frame_open_reg) && in_win
                          && mask[rel[4:0]];
         // Bitwise CRC-16 over one byte, LSB first
         always_comb begin
            logic [15:0] c;
            c = rx_sof_in ? wfpd_pkg::CRC_INIT : crc_reg;
            for (int b = 0; b < 8; b++) begin
               if (c[15] ^ rx_data_in[b]) begin
                  c = {c[14:0], 1'b0} ^ wfpd_pkg::CRC_POLY;
               end else begin
                  c = {c[14:0], 1'b0};
               end
            end
            crc_next = c;
         end
         always_ff @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
               crc_reg <= wfpd_pkg::CRC_INIT;
            end else if (rx_valid_in && rx_sof_in) begin
               crc_reg <= take ? crc_next : wfpd_pkg::CRC_INIT;
            end else if (take) begin
               crc_reg <= crc_next;
            end
         end
         // The closing byte may itself be masked in, so judge on the updated CRC
         assign crc_now = take ? crc_next : crc_reg;
         // Multicast filters also accept broadcast, as broadcast is multicast
         assign type_ok = cmd[wfpd_pkg::CMD_MCAST_BIT] ? is_mcast_reg : !is_mcast_reg;
         assign hit[g]  = cmd[wfpd_pkg::CMD_ENABLE_BIT] && type_ok
                          && crc_now == ref_crc;
      end
   endgenerate

   // Verdict at frame end, only for good frames; broadcast disable not consulted
   assign wake_event = active && rx_valid_in && rx_eof_in && frame_open_reg && !rx_sof_in
                       && rx_fcs_ok_in
                       && (rx_addr_match_in || is_broadcast_disable_reg)
                       && |hit;

   // Mode outputs
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         detect_active_out    <= 1'b0;
         normal_rx_enable_out <= 1'b1;
      end else begin
         detect_active_out    <= active;
         normal_rx_enable_out <= !active;
      end
   end

   // Sticky flag; a new event beats a same-cycle clear
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wake_frame_received_flag_out <= 1'b0;
      end else if (wake_event) begin
         wake_frame_received_flag_out <= 1'b1;
      end else if (flag_clear_in) begin
         wake_frame_received_flag_out <= 1'b0;
      end
   end

   // Notification follows the flag so it holds until cleared
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         host_irq_out           <= 1'b0;
         power_event_signal_out <= 1'b0;
      end else begin
         host_irq_out           <= irq_select_in && (wake_event || (wake_frame_received_flag_out && !flag_clear_in));
         power_event_signal_out <= pme_select_in && (wake_event || (wake_frame_received_flag_out && !flag_clear_in));
      end
   end

   // Broadcast disable only gates normal reception, which lives outside this block
   logic unused_ok;
   assign unused_ok = broadcast_disable_in; // deliberately ignored
endmodule : wfpd_detector
`default_nettype wire

// [verification/wfpd_detector_assertions.sv]
`default_nettype none
module wfpd_detector_assertions #(
   parameter int NUM_FILTERS = 4
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic rx_valid_in,
   input wire logic rx_eof_in,
   input wire logic rx_fcs_ok_in,
   input wire logic wake_frame_enable_in,
   input wire logic low_power_state_in,
   input wire logic irq_select_in,
   input wire logic pme_select_in,
   input wire logic flag_clear_in,
   input wire logic detect_active_out,
   input wire logic normal_rx_enable_out,
   input wire logic wake_frame_received_flag_out,
   input wire logic host_irq_out,
   input wire logic power_event_signal_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // Either source of enable turns detection on next cycle
   a_detect_on_mode: assert property ((wake_frame_enable_in || low_power_state_in) |=> detect_active_out)
      else $error("detection not active after enable");
   a_detect_off_mode: assert property (!(wake_frame_enable_in || low_power_state_in) |=> !detect_active_out)
      else $error("detection still active after disable");
   a_normal_rx_inv: assert property (normal_rx_enable_out == !detect_active_out)
      else $error("normal reception not opposite to detection");
   a_flag_cause_good: assert property (
      $rose(wake_frame_received_flag_out) |-> $past(rx_eof_in && rx_valid_in && rx_fcs_ok_in))
      else $error("flag set without good frame end");
   a_flag_hold_sticky: assert property (
      wake_frame_received_flag_out && !flag_clear_in |=> wake_frame_received_flag_out)
      else $error("flag dropped without clear");
   a_flag_clear_drop: assert property (flag_clear_in && !rx_eof_in |=> !wake_frame_received_flag_out)
      else $error("flag survived clear");
   // Both notifications are the flag gated by the select seen one edge earlier
   a_irq_route_set: assert property (
      host_irq_out == ($past(irq_select_in) && wake_frame_received_flag_out))
      else $error("interrupt does not follow flag and select");
   a_pme_route_set: assert property (
      power_event_signal_out == ($past(pme_select_in) && wake_frame_received_flag_out))
      else $error("power event does not follow flag and select");
   c_wake_irq: cover property ($rose(host_irq_out));
   c_wake_pme: cover property ($rose(power_event_signal_out));
   c_flag_clear: cover property (wake_frame_received_flag_out && flag_clear_in);
endmodule : wfpd_detector_assertions
bind wfpd_detector wfpd_detector_assertions #(.NUM_FILTERS(NUM_FILTERS)) i_chk (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .rx_valid_in(rx_valid_in), .rx_eof_in(rx_eof_in),
   .rx_fcs_ok_in(rx_fcs_ok_in), .wake_frame_enable_in(wake_frame_enable_in),
   .low_power_state_in(low_power_state_in), .irq_select_in(irq_select_in), .pme_select_in(pme_select_in),
   .flag_clear_in(flag_clear_in), .detect_active_out(detect_active_out),
   .normal_rx_enable_out(normal_rx_enable_out), .wake_frame_received_flag_out(wake_frame_received_flag_out),
   .host_irq_out(host_irq_out), .power_event_signal_out(power_event_signal_out));
`default_nettype wire

// [verification/wfpd_rx_source.sv]
`default_nettype none
// Far-side frame source: 17 bytes, byte 0 sets address type
module wfpd_rx_source (
   input  wire logic       clk_sys_in,
   input  wire logic       go_in,
   input  wire logic [7:0] dest_in,
   output logic            sof_out = 1'b0,
   output logic            valid_out = 1'b0,
   output logic      [7:0] data_out = 8'h00,
   output logic            eof_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int pos = -1;
   int n;
   // Idle data inverts each cycle so a stale byte never looks live
   always @(posedge clk_sys_in) begin
      n = go_in ? 0 : ((pos >= 0 && pos < 16) ? pos + 1 : -1);
      pos       <= n;
      valid_out <= (n >= 0);
      sof_out   <= (n == 0);
      eof_out   <= (n == 16);
      // A broadcast destination repeats ff over all six address bytes
      data_out  <= (n == 0 || (n > 0 && n < 6 && dest_in == 8'hff)) ? dest_in
                   : ((n > 0) ? 8'(n) : ~data_out);
   end
endmodule : wfpd_rx_source
`default_nettype wire

// [verification/test_wfpd_detector.sv]
`default_nettype none
module test_wfpd_detector;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, en = 1'b0, lp = 1'b0;
   logic isel = 1'b1, psel = 1'b0, clr = 1'b0, bc_off = 1'b1, go = 1'b0, fcs = 1'b0, am = 1'b0;
   logic [7:0] dest = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic sof, valid, eof, act, nrx, flag, irq, power_event_signal;
   logic [7:0] data;
   logic [31:0] w [8];
   logic [15:0] c;
   int miscompares = 0, cmp_count = 0;
   initial forever #50 clk_sys_in = ~clk_sys_in;
   wfpd_detector i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst), .filter_wr_in(wr), .filter_wdata_in(wdata),
      .filter_rd_in(rd), .filter_rdata_out(rdata), .wake_frame_enable_in(en), .low_power_state_in(lp),
      .irq_select_in(isel), .pme_select_in(psel), .flag_clear_in(clr), .broadcast_disable_in(bc_off),
      .rx_sof_in(sof), .rx_valid_in(valid), .rx_data_in(data), .rx_eof_in(eof), .rx_fcs_ok_in(fcs),
      .rx_addr_match_in(am), .detect_active_out(act), .normal_rx_enable_out(nrx),
      .wake_frame_received_flag_out(flag), .host_irq_out(irq), .power_event_signal_out(power_event_signal));
   wfpd_rx_source i_src (.clk_sys_in(clk_sys_in), .go_in(go), .dest_in(dest), .sof_out(sof),
      .valid_out(valid), .data_out(data), .eof_out(eof));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // CRC over bytes 14 and 16, bits taken LSB first
   function automatic logic [15:0] crc16(input logic [15:0] b);
      logic [15:0] r;
      r = wfpd_pkg::CRC_INIT;
      for (int i = 0; i < 16; i++) r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? wfpd_pkg::CRC_POLY : 16'h0);
      return r;
   endfunction : crc16
   // Waits past the eof byte, then looks at the sticky flag
   task automatic frame(input logic [7:0] d0, input logic f, input logic a, input logic e);
      @(posedge clk_sys_in);
      go <= 1'b1;
      dest <= d0;
      fcs <= f;
      am <= a;
      @(posedge clk_sys_in);
      go <= 1'b0;
      repeat (19) @(posedge clk_sys_in);
      #1 chk(flag, e);
   endtask : frame
   // Eight back-to-back words; the write index wraps so a reload starts at word 0
   task automatic load;
      foreach (w[i]) begin
         @(posedge clk_sys_in);
         wr <= 1'b1;
         wdata <= w[i];
      end
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask : load
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   initial begin
      #200000 miscompares++;
      conclude();
   end
   initial begin
      c = crc16({8'h10, 8'h0e});
      // Filter 0 unicast on, 1 multicast off, 2 multicast on with wrong CRC
      w = '{32'h8000_0005, 32'h5, 32'h5, 32'h0, 32'h0009_0801, 32'h0e0e_0e0e, {c, c}, {c, c ^ 16'h1}};
      repeat (6) @(posedge clk_sys_in);
      rst <= 1'b0;
      #1 chk({act, nrx, flag}, 3'b010);
      load();
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_sys_in);
         rd <= 1'b1;
         @(posedge clk_sys_in);
         rd <= 1'b0;
         #1 chk(rdata, (i % 8 == 0) ? 32'h5 : w[i % 8]);
      end
      $display("test filter load done");
      @(posedge clk_sys_in);
      en <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1 chk({act, nrx}, 2'b10);
      frame(8'h00, 1'b1, 1'b1, 1'b1);
      chk({irq, power_event_signal}, 2'b10);
      @(posedge clk_sys_in);
      clr <= 1'b1;
      @(posedge clk_sys_in);
      clr <= 1'b0;
      #1 chk({flag, irq}, 2'b00);
      frame(8'h00, 1'b0, 1'b1, 1'b0);
      frame(8'h00, 1'b1, 1'b0, 1'b0);
      frame(8'h01, 1'b1, 1'b1, 1'b0);
      $display("test wake match done");
      @(posedge clk_sys_in);
      en <= 1'b0;
      frame(8'h00, 1'b1, 1'b1, 1'b0);
      chk(nrx, 1'b1);
      @(posedge clk_sys_in);
      lp <= 1'b1;
      isel <= 1'b0;
      psel <= 1'b1;
      frame(8'h00, 1'b1, 1'b1, 1'b1);
      chk({irq, power_event_signal}, 2'b01);
      $display("test power modes done");
      // Filter 3 becomes a multicast filter with the good CRC, reloaded after the wrap
      @(posedge clk_sys_in);
      clr <= 1'b1;
      lp <= 1'b0;
      en <= 1'b1;
      w[3] = 32'h0000_0005;
      w[4] = 32'h0909_0801;
      @(posedge clk_sys_in);
      clr <= 1'b0;
      #1 chk({flag, power_event_signal}, 2'b00);
      load();
      frame(8'hff, 1'b1, 1'b0, 1'b1);
      chk({irq, power_event_signal}, 2'b01);
      $display("test broadcast wake done");
      conclude();
   end
endmodule : test_wfpd_detector
`default_nettype wire
